// ==== rtl/ues_event_core.sv ====
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - Summary bit 0 is high while endpoint A holds an enabled cause.
// - Control endpoint status is 8 bits at index B5, reset to zero.
// - Writing one to any status bit clears that flag, unless an event sets it in the same cycle.
// - Descriptor done sets once the programmed reply byte count is sent.
// - OUT token before reply end sets descriptor done and OUT NAK.
// - Short-packet ACK flag sets together with the OUT ACK flag.
// - IN ACK flag sets when host acknowledges IN data.
// - OUT ACK flag sets when device acknowledges OUT data.
// - IN NAK flag sets when an IN token gets NAK.
// - OUT NAK flag sets when OUT or PING gets NAK.
// - IN fault sets on STALL, packet error or handshake timeout.
// - OUT fault sets on STALL or received packet error.
// - Endpoint A status at index B6, bit 7 reserved.
// - Endpoint B status at index B7, same layout as A.
module ues_event_core
#(
    parameter int COUNT_W = 10
)
(
    input  wire logic               core_clk,
    input  wire logic               arst_n,
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               we_i,
    input  wire logic [11:0]        adr_i,
    input  wire logic [3:0]         sel_i,
    input  wire logic [31:0]        dat_i,
    output logic      [31:0]        dat_o,
    output logic                    ack_o,
    input  wire logic [6:0]         ctrlEvent,
    input  wire logic [6:0]         epAEvent,
    input  wire logic [6:0]         epBEvent,
    input  wire logic               replyStart,
    input  wire logic               replyByte,
    input  wire logic               ctrlOutToken,
    output logic                    irq
);
    import ues_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    generate
        if (COUNT_W < 1 || COUNT_W > 16)
        begin : g_bad_width
            $error("COUNT_W must lie in 1..16");
        end
    endgenerate

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [11:0] adr, input logic [9:0] idx);
        hit = (adr[11:2] == idx);
    endfunction

    logic               request;
    logic               writeEn;
    logic               lane0;
    logic               lane1;
    logic [7:0]         wrByte;
    logic [7:0]         ctrlFlags;
    logic [7:0]         epAFlags;
    logic [7:0]         epBFlags;
    logic [7:0]         epAEnable;
    logic [7:0]         ctrlMask;
    logic [7:0]         epBMask;
    logic [COUNT_W-1:0] replyCount;
    logic               replyDone;
    logic               replyCutNak;
    logic               summaryA;
    logic               next_irq;
    logic [31:0]        next_dat;
    logic [7:0]         clear [3];
    logic [7:0]         setEv [3];
    logic [6:0]         epEv  [3];
    logic [9:0]         statIdx [3];
    logic [7:0]         flagsOf [3];

    // Bus request is taken in the cycle before ack rises
    assign request = cyc_i && stb_i && !ack_o;
    assign writeEn = request && we_i;
    assign lane0   = sel_i[0];
    assign lane1   = sel_i[1];
    assign wrByte  = dat_i[7:0];

    // ------------------------------------------------------------
    // Wishbone answer
    // ------------------------------------------------------------
    // Every access is acknowledged; unmapped reads return zero
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_o <= 1'b0;
        end
        else
        begin
            ack_o <= request;
        end
    end

    always_comb
    begin
        next_dat = 32'h0000_0000;
        if (hit(adr_i, IDX_CTRL_STAT))
            next_dat[7:0] = ctrlFlags;
        else if (hit(adr_i, IDX_A_STAT))
            next_dat[7:0] = epAFlags;
        else if (hit(adr_i, IDX_B_STAT))
            next_dat[7:0] = epBFlags;
        else if (hit(adr_i, IDX_A_ENABLE))
            next_dat[7:0] = epAEnable;
        else if (hit(adr_i, IDX_SUMMARY))
            next_dat[SUM_BIT_A] = summaryA;
        else if (hit(adr_i, IDX_REPLY_COUNT))
            next_dat[COUNT_W-1:0] = replyCount;
        else if (hit(adr_i, IDX_CTRL_MASK))
            next_dat[7:0] = ctrlMask;
        else if (hit(adr_i, IDX_B_MASK))
            next_dat[7:0] = epBMask;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dat_o <= 32'h0000_0000;
        end
        else if (request && !we_i)
        begin
            dat_o <= next_dat;
        end
    end

    // ------------------------------------------------------------
    // Software-written controls
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            epAEnable <= MASK_RESET;
            ctrlMask  <= MASK_RESET;
            epBMask   <= MASK_RESET;
        end
        else if (writeEn && lane0)
        begin
            if (hit(adr_i, IDX_A_ENABLE))
                epAEnable <= wrByte & VALID_EP;
            if (hit(adr_i, IDX_CTRL_MASK))
                ctrlMask <= wrByte & VALID_CTRL;
            if (hit(adr_i, IDX_B_MASK))
                epBMask <= wrByte & VALID_EP;
        end
    end

    // Count up to 16 bits spans two byte lanes
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            replyCount <= COUNT_W'(COUNT_RESET);
        end
        else if (writeEn && hit(adr_i, IDX_REPLY_COUNT))
        begin
            for (int b = 0; b < COUNT_W; b++)
            begin
                if ((b < 8) ? lane0 : lane1)
                    replyCount[b] <= dat_i[b];
            end
        end
    end

    // ------------------------------------------------------------
    // Descriptor reply tracking
    // ------------------------------------------------------------
    // byte counting against programmed count
    ues_desc_reply #(
        .COUNT_W     (COUNT_W)
    ) u_reply (
        .core_clk    (core_clk),
        .arst_n      (arst_n),
        .replyCount  (replyCount),
        .replyStart  (replyStart),
        .replyByte   (replyByte),
        .outToken    (ctrlOutToken),
        .replyDone   (replyDone),
        .replyCutNak (replyCutNak)
    );

    // ------------------------------------------------------------
    // Endpoint status registers
    // ------------------------------------------------------------
    assign epEv[0]    = ctrlEvent;
    assign epEv[1]    = epAEvent;
    assign epEv[2]    = epBEvent;
    assign statIdx[0] = IDX_CTRL_STAT;
    assign statIdx[1] = IDX_A_STAT;
    assign statIdx[2] = IDX_B_STAT;
    assign ctrlFlags  = flagsOf[0];
    assign epAFlags   = flagsOf[1];
    assign epBFlags   = flagsOf[2];

    genvar e;
    generate
        for (e = 0; e < 3; e++)
        begin : g_ep
            // short ACK only with OUT ACK
            // control endpoint OUT NAK also from cut reply
            always_comb
            begin
                setEv[e] = 8'h00;
                setEv[e][BIT_OUT_FAULT] = epEv[e][BIT_OUT_FAULT];
                setEv[e][BIT_IN_FAULT]  = epEv[e][BIT_IN_FAULT];
                setEv[e][BIT_OUT_NAK]   = epEv[e][BIT_OUT_NAK];
                setEv[e][BIT_IN_NAK]    = epEv[e][BIT_IN_NAK];
                setEv[e][BIT_OUT_ACK]   = epEv[e][BIT_OUT_ACK];
                setEv[e][BIT_IN_ACK]    = epEv[e][BIT_IN_ACK];
                setEv[e][BIT_SHORT_ACK] = epEv[e][BIT_SHORT_ACK]
                                        && epEv[e][BIT_OUT_ACK];
                if (e == 0)
                begin
                    setEv[e][BIT_DESC_DONE] = replyDone;
                    setEv[e][BIT_OUT_NAK]   = epEv[e][BIT_OUT_NAK]
                                            || replyCutNak;
                end
            end

            assign clear[e] = (writeEn && lane0 && hit(adr_i, statIdx[e]))
                            ? wrByte : 8'h00;

            ues_flag_reg #(
                .VALID     (e == 0 ? VALID_CTRL : VALID_EP)
            ) u_flags (
                .core_clk  (core_clk),
                .arst_n    (arst_n),
                .setEvent  (setEv[e]),
                .clearMask (clear[e]),
                .flags     (flagsOf[e])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Summary and interrupt
    // ------------------------------------------------------------
    // enabled endpoint A cause
    assign summaryA = |(epAFlags & epAEnable);

    // Registered so the pin never glitches on a clear
    assign next_irq = summaryA
                    || (|(ctrlFlags & ctrlMask))
                    || (|(epBFlags & epBMask));

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence

    sequence s_ack_pulse;
        ack_o ##1 !ack_o;
    endsequence

    // Ack comes one cycle after the request and lasts one cycle
    a_bus_answer: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_req |=> s_ack_pulse)
        else $error("bus answer not one-cycle ack");

    a_summary_bit: assert property (@(posedge core_clk) disable iff (!arst_n)
        (|(epAFlags & epAEnable)) |-> ##1 irq)
        else $error("summary did not raise interrupt");

    // short ACK paired with OUT ACK
    a_short_pair: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(ctrlFlags[BIT_SHORT_ACK]) |-> ctrlFlags[BIT_OUT_ACK])
        else $error("short ACK without OUT ACK");

    a_out_ack_set: assert property (@(posedge core_clk) disable iff (!arst_n)
        epAEvent[BIT_OUT_ACK] |=> epAFlags[BIT_OUT_ACK])
        else $error("OUT ACK flag not set");

    // reserved bit of endpoint A reads zero
    a_epa_reserved: assert property (@(posedge core_clk) disable iff (!arst_n)
        (ack_o && $past(hit(adr_i, IDX_A_STAT)) && !$past(we_i)) |-> !dat_o[7])
        else $error("endpoint A bit 7 read as one");

    // cut reply sets both control flags
    a_cut_flags: assert property (@(posedge core_clk) disable iff (!arst_n)
        replyCutNak |=> (ctrlFlags[BIT_DESC_DONE] && ctrlFlags[BIT_OUT_NAK]))
        else $error("cut reply flags missing");

    a_desc_flag: assert property (@(posedge core_clk) disable iff (!arst_n)
        replyDone |=> ctrlFlags[BIT_DESC_DONE])
        else $error("descriptor done flag not set");

    a_in_ack_set: assert property (@(posedge core_clk) disable iff (!arst_n)
        epBEvent[BIT_IN_ACK] |=> epBFlags[BIT_IN_ACK])
        else $error("IN ACK flag not set");

    a_in_nak_set: assert property (@(posedge core_clk) disable iff (!arst_n)
        ctrlEvent[BIT_IN_NAK] |=> ctrlFlags[BIT_IN_NAK])
        else $error("IN NAK flag not set");

    a_out_nak_set: assert property (@(posedge core_clk) disable iff (!arst_n)
        epAEvent[BIT_OUT_NAK] |=> epAFlags[BIT_OUT_NAK])
        else $error("OUT NAK flag not set");

    a_in_fault_set: assert property (@(posedge core_clk) disable iff (!arst_n)
        epBEvent[BIT_IN_FAULT] |=> epBFlags[BIT_IN_FAULT])
        else $error("IN fault flag not set");

    a_out_fault_set: assert property (@(posedge core_clk) disable iff (!arst_n)
        ctrlEvent[BIT_OUT_FAULT] |=> ctrlFlags[BIT_OUT_FAULT])
        else $error("OUT fault flag not set");

    a_zero_keeps: assert property (@(posedge core_clk) disable iff (!arst_n)
        (writeEn && lane0 && hit(adr_i, IDX_A_STAT) && !wrByte[BIT_IN_ACK]
        && epAFlags[BIT_IN_ACK]) |=> epAFlags[BIT_IN_ACK])
        else $error("zero write changed a flag");

endmodule

// ==== rtl/ues_pkg.sv ====
package ues_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_CTRL_STAT   = 10'h0B5;
    localparam logic [9:0] IDX_A_STAT      = 10'h0B6;
    localparam logic [9:0] IDX_B_STAT      = 10'h0B7;
    localparam logic [9:0] IDX_A_ENABLE    = 10'h0C0;
    localparam logic [9:0] IDX_SUMMARY     = 10'h0C1;
    localparam logic [9:0] IDX_REPLY_COUNT = 10'h0C2;
    localparam logic [9:0] IDX_CTRL_MASK   = 10'h0C4;
    localparam logic [9:0] IDX_B_MASK      = 10'h0C5;

    // ------------------------------------------------------------
    // Event flag positions
    // ------------------------------------------------------------
    localparam int BIT_OUT_FAULT  = 0;
    localparam int BIT_IN_FAULT   = 1;
    localparam int BIT_OUT_NAK    = 2;
    localparam int BIT_IN_NAK     = 3;
    localparam int BIT_OUT_ACK    = 4;
    localparam int BIT_IN_ACK     = 5;
    localparam int BIT_SHORT_ACK  = 6;
    localparam int BIT_DESC_DONE  = 7;
    localparam int SUM_BIT_A      = 0;

    // ------------------------------------------------------------
    // Reset values and implemented-bit masks
    // ------------------------------------------------------------
    localparam logic [7:0] STAT_RESET  = 8'h00;
    localparam logic [7:0] MASK_RESET  = 8'h00;
    localparam logic [7:0] VALID_CTRL  = 8'hFF;
    localparam logic [7:0] VALID_EP    = 8'h7F;
    localparam int         COUNT_RESET = 0;

    typedef enum logic [0:0] {
        UES_IDLE = 1'b0,
        UES_SEND = 1'b1
    } ues_reply_e;

endpackage

// ==== rtl/ues_flag_reg.sv ====
`timescale 1ns/1ps
module ues_flag_reg
#(
    parameter logic [7:0] VALID = 8'hFF
)
(
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic [7:0] setEvent,
    input  wire logic [7:0] clearMask,
    output logic      [7:0] flags
);
    import ues_pkg::*;

    // ------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------
    // write-one clears, set wins
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flags <= STAT_RESET;
        end
        else
        begin
            flags <= ((flags & ~clearMask) | setEvent) & VALID;
        end
    end

    a_set_wins: assert property (@(posedge core_clk) disable iff (!arst_n)
        (|(setEvent & VALID)) |=> ((flags & $past(setEvent) & VALID) == ($past(setEvent) & VALID)))
        else $error("event flag lost");

    a_clear_one: assert property (@(posedge core_clk) disable iff (!arst_n)
        (clearMask[0] && !setEvent[0]) |=> !flags[0])
        else $error("write-one did not clear");

    a_reserved_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
        (flags & ~VALID) == 8'h00)
        else $error("reserved flag set");

endmodule

// ==== rtl/ues_desc_reply.sv ====
`timescale 1ns/1ps
module ues_desc_reply
#(
    parameter int COUNT_W = 10
)
(
    input  wire logic               core_clk,
    input  wire logic               arst_n,
    input  wire logic [COUNT_W-1:0] replyCount,
    input  wire logic               replyStart,
    input  wire logic               replyByte,
    input  wire logic               outToken,
    output logic                    replyDone,
    output logic                    replyCutNak
);
    import ues_pkg::*;

    ues_reply_e         state;
    logic [COUNT_W-1:0] sent;
    logic [COUNT_W-1:0] next_sent;

    assign next_sent = sent + 1'b1;

    // ------------------------------------------------------------
    // Reply progress
    // ------------------------------------------------------------
    // completion or early status stage
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state       <= UES_IDLE;
            sent        <= COUNT_W'(COUNT_RESET);
            replyDone   <= 1'b0;
            replyCutNak <= 1'b0;
        end
        else
        begin
            replyDone   <= 1'b0;
            replyCutNak <= 1'b0;
            unique case (state)
                UES_IDLE:
                begin
                    sent <= COUNT_W'(COUNT_RESET);
                    if (replyStart)
                    begin
                        if (replyCount == '0)
                            replyDone <= 1'b1;
                        else
                            state <= UES_SEND;
                    end
                end
                UES_SEND:
                begin
                    if (outToken)
                    begin
                        replyDone   <= 1'b1;
                        replyCutNak <= 1'b1;
                        state       <= UES_IDLE;
                    end
                    else if (replyByte)
                    begin
                        sent <= next_sent;
                        if (next_sent == replyCount)
                        begin
                            replyDone <= 1'b1;
                            state     <= UES_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    a_reply_full: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state == UES_SEND && replyByte && !outToken && next_sent == replyCount)
        |=> (replyDone && !replyCutNak && state == UES_IDLE))
        else $error("reply done missing after last byte");

    a_reply_cut: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state == UES_SEND && outToken) |=> (replyDone && replyCutNak))
        else $error("early status stage not flagged");

endmodule

// ==== dv/ues_usb_host.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host side: token outcomes seen by the endpoint logic
// ------------------------------------------------------------
module ues_usb_host
(
    input  wire logic       core_clk,
    output logic      [6:0] ctrlEvent,
    output logic      [6:0] epAEvent,
    output logic      [6:0] epBEvent,
    output logic            replyStart,
    output logic            replyByte,
    output logic            ctrlOutToken
);
    initial
    begin
        ctrlEvent    = '0;
        epAEvent     = '0;
        epBEvent     = '0;
        replyStart   = 1'b0;
        replyByte    = 1'b0;
        ctrlOutToken = 1'b0;
    end

    // One-cycle outcome pulse; kinds 0..2 are endpoints, 3..5 reply steps.
    // Called just after a rising edge, so the pulse spans exactly one cycle.
    // Only the driven signal is lowered, so a pulse of another kind may
    // start at the same edge without assigning one signal twice.
    task automatic drive(input int kind, input logic [6:0] v);
    begin
        case (kind)
            0: ctrlEvent <= v;
            1: epAEvent <= v;
            2: epBEvent <= v;
            3: replyStart <= v[0];
            4: replyByte <= v[0];
            default: ctrlOutToken <= v[0];
        endcase
    end
    endtask

    task automatic pulse(input int kind, input logic [6:0] v);
    begin
        drive(kind, (kind < 3) ? v : 7'h01);
        @(posedge core_clk);
        drive(kind, 7'h00);
    end
    endtask
endmodule

// ==== dv/usb_endpoint_event_status_bench.sv ====
`timescale 1ns/1ps
module usb_endpoint_event_status_bench;
    import ues_pkg::*;
    logic        core_clk;
    logic        arst_n;
    logic        cyc, stb, we, ack, irq;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] datW, datR;
    logic [6:0]  evC, evA, evB;
    logic        rStart, rByte, rOut;
    logic [7:0]  q, exp8, clr;
    logic [6:0]  ev;
    int          nFail, nTests, cycles;

    always #12.5 core_clk = ~core_clk;

    ues_usb_host host (.core_clk(core_clk), .ctrlEvent(evC), .epAEvent(evA),
        .epBEvent(evB), .replyStart(rStart), .replyByte(rByte), .ctrlOutToken(rOut));

    ues_event_core #(.COUNT_W(10)) dut (.core_clk(core_clk), .arst_n(arst_n),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW),
        .dat_o(datR), .ack_o(ack), .ctrlEvent(evC), .epAEvent(evA), .epBEvent(evB),
        .replyStart(rStart), .replyByte(rByte), .ctrlOutToken(rOut), .irq(irq));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic stopTest();
    begin
        $display("checks %0d mismatches %0d", nTests, nFail);
        if (nFail == 0 && nTests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask

    // Cycle ceiling: the whole run needs under a thousand cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles >= 20000)
        begin
            nFail++;
            stopTest();
        end
    end

    function automatic logic [11:0] statAdr(input int ep);
        return {IDX_CTRL_STAT + 10'(ep), 2'b00};
    endfunction

    // Short flag is only meaningful beside the OUT ACK flag
    function automatic logic [7:0] evFlags(input logic [6:0] e);
        return {1'b0, e[6] & e[4], e[5:0]};
    endfunction

    task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] g);
    begin
        nTests++;
        if (g !== e)
        begin
            nFail++;
            $display("[FAIL] %s expected %h seen %h", name, e, g);
        end
    end
    endtask

    task automatic chk1(input string name, input logic e, input logic g);
    begin
        nTests++;
        if (g !== e)
        begin
            nFail++;
            $display("[FAIL] %s expected %b seen %b", name, e, g);
        end
    end
    endtask

    // Classic single cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
    begin
        n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hF;
        datW <= {24'h000000, d};
        do
        begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20)
            nFail++;
        q = datR[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge core_clk);
    end
    endtask

    task automatic rdChk(input string name, input logic [11:0] a, input logic [7:0] e);
    begin
        wb(1'b0, a, 8'h00);
        chk8(name, e, q);
    end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        arst_n = 1'b0;
        {cyc, stb, we} = 3'b000;
        adr = 12'h000;
        sel = 4'h0;
        datW = 32'h00000000;
        nFail = 0;
        nTests = 0;
        cycles = 0;
        void'($urandom(630));
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);

        for (int e = 0; e < 3; e++)
            rdChk("status reset", statAdr(e), STAT_RESET);
        rdChk("summary reset", {IDX_SUMMARY, 2'b00}, 8'h00);
        wb(1'b1, 12'hFFC, 8'hFF);
        rdChk("unmapped read", 12'hFFC, 8'h00);
        $display("test reset done");

        for (int e = 0; e < 3; e++)
        begin
            for (int b = 0; b < 6; b++)
            begin
                host.pulse(e, 7'(1 << b));
                rdChk("flag set", statAdr(e), 8'(1 << b));
                wb(1'b1, statAdr(e), 8'h00);
                rdChk("zero write", statAdr(e), 8'(1 << b));
                wb(1'b1, statAdr(e), 8'(1 << b));
                rdChk("one clears", statAdr(e), 8'h00);
            end
            host.pulse(e, 7'h50);
            rdChk("short with ack", statAdr(e), 8'h50);
            wb(1'b1, statAdr(e), 8'hFF);
        end
        $display("test flags done");

        host.pulse(2, 7'h7F);
        wb(1'b1, statAdr(2), 8'h80);
        rdChk("reserved bit", statAdr(2), 8'h7F);
        wb(1'b1, statAdr(2), 8'hFF);
        host.pulse(1, 7'h20);
        @(posedge core_clk);
        fork
            host.pulse(1, 7'h20);
            wb(1'b1, statAdr(1), 8'h20);
        join
        rdChk("set beats clear", statAdr(1), 8'h20);
        wb(1'b1, statAdr(1), 8'hFF);
        $display("test collide done");

        wb(1'b1, {IDX_A_ENABLE, 2'b00}, 8'h10);
        host.pulse(1, 7'h08);
        repeat (3) @(posedge core_clk);
        chk1("irq masked", 1'b0, irq);
        rdChk("summary masked", {IDX_SUMMARY, 2'b00}, 8'h00);
        host.pulse(1, 7'h10);
        repeat (3) @(posedge core_clk);
        chk1("irq raised", 1'b1, irq);
        rdChk("summary set", {IDX_SUMMARY, 2'b00}, 8'h01);
        wb(1'b1, statAdr(1), 8'h10);
        repeat (3) @(posedge core_clk);
        chk1("irq cleared", 1'b0, irq);
        wb(1'b1, statAdr(1), 8'hFF);
        wb(1'b1, {IDX_A_ENABLE, 2'b00}, 8'h00);
        $display("test summary done");

        wb(1'b1, {IDX_CTRL_MASK, 2'b00}, 8'h04);
        wb(1'b1, {IDX_B_MASK, 2'b00}, 8'h01);
        host.pulse(2, 7'h01);
        repeat (3) @(posedge core_clk);
        chk1("irq endpoint B", 1'b1, irq);
        rdChk("summary B only", {IDX_SUMMARY, 2'b00}, 8'h00);
        wb(1'b1, statAdr(2), 8'hFF);
        repeat (3) @(posedge core_clk);
        chk1("irq B cleared", 1'b0, irq);
        host.pulse(0, 7'h7F);
        repeat (3) @(posedge core_clk);
        chk1("irq control", 1'b1, irq);
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        chk1("irq after reset", 1'b0, irq);
        rdChk("status after reset", statAdr(0), STAT_RESET);
        rdChk("mask after reset", {IDX_CTRL_MASK, 2'b00}, MASK_RESET);
        $display("test mask done");

        wb(1'b1, {IDX_REPLY_COUNT, 2'b00}, 8'h02);
        host.pulse(3, 7'h00);
        host.pulse(4, 7'h00);
        repeat (3) @(posedge core_clk);
        rdChk("reply partial", statAdr(0), 8'h00);
        host.pulse(4, 7'h00);
        repeat (3) @(posedge core_clk);
        rdChk("reply done", statAdr(0), 8'h80);
        wb(1'b1, statAdr(0), 8'hFF);
        wb(1'b1, {IDX_REPLY_COUNT, 2'b00}, 8'h03);
        host.pulse(3, 7'h00);
        host.pulse(4, 7'h00);
        host.pulse(5, 7'h00);
        repeat (3) @(posedge core_clk);
        rdChk("reply cut", statAdr(0), 8'h84);
        wb(1'b1, statAdr(0), 8'hFF);
        $display("test reply done");

        for (int e = 0; e < 3; e++)
        begin
            exp8 = 8'h00;
            for (int i = 0; i < 8; i++)
            begin
                ev = 7'($urandom);
                exp8 = exp8 | evFlags(ev);
                host.pulse(e, ev);
                rdChk("random set", statAdr(e), exp8);
                clr = 8'($urandom);
                wb(1'b1, statAdr(e), clr);
                exp8 = exp8 & ~clr;
                rdChk("random clear", statAdr(e), exp8);
            end
            wb(1'b1, statAdr(e), 8'hFF);
        end
        $display("test random done");
        stopTest();
    end
endmodule
